// ===== hdl/pcdv_defs.svh
/*
 * Constants of the pin control decoder: timing, codes, volume limits,
 * register offsets and field positions.
 * Assumes a 40 ns system clock and one inclusion per compile unit.
 */
`ifndef PCDV_DEFS_SVH
`define PCDV_DEFS_SVH

// Clock period and derived cycle counts
`define PCDV_CLK_NS          40
`define PCDV_SAMPLE_NS       125000
`define PCDV_SAMPLE_CYC      (`PCDV_SAMPLE_NS / `PCDV_CLK_NS)
`define PCDV_MUTE_DLY_NS     1000000
`define PCDV_MUTE_DLY_CYC    ((`PCDV_MUTE_DLY_NS + `PCDV_CLK_NS - 1) / `PCDV_CLK_NS)
`define PCDV_ERR_NS          125000
`define PCDV_ERR_CYC         (`PCDV_ERR_NS / `PCDV_CLK_NS)
`define PCDV_DEB_SAMPLES     2'h3

// Command codes on the three command pins
`define PCDV_CMD_HD_EN       3'h0
`define PCDV_CMD_CLR         3'h1
`define PCDV_CMD_HD_DIS_A    3'h3
`define PCDV_CMD_VOL_DN      3'h5
`define PCDV_CMD_VOL_UP      3'h6
`define PCDV_CMD_HD_DIS_B    3'h7

// Volume increment counter
`define PCDV_VOL_RESET       6'h04
`define PCDV_VOL_MIN         6'h00
`define PCDV_VOL_MAX         6'h29
`define PCDV_VOL_MAX_AGC_DISABLE_BIT    6'h1F
`define PCDV_VOL_KNEE        6'h0A
`define PCDV_AGC_STEP_DB     8'h03
`define PCDV_DAC_STEP_HDB    8'h05
`define PCDV_AGC_DISABLE_BIT_STEPS      6'h04

// Register offsets (byte addresses)
`define PCDV_REG_CTRL        8'h00
`define PCDV_REG_STATUS      8'h04
`define PCDV_REG_VOLUME      8'h08

// Control register fields
`define PCDV_CTRL_AGC_DISABLE_BIT       0
`define PCDV_CTRL_MODE16     1

// Status register fields
`define PCDV_ST_HD_EN        0
`define PCDV_ST_CLR          1
`define PCDV_ST_MUTE         2
`define PCDV_ST_MIC_GAIN     3
`define PCDV_ST_RANGE_ERR    4
`define PCDV_ST_HD_STATUS    5
`define PCDV_ST_AGC_ACT      6

`endif

// ===== hdl/pcdv_pkg.sv
/*
 * Types of the pin control decoder: bus carrier, phases, state record.
 * Assumes the constants header is compiled alongside.
 */
package pcdv_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } pcdv_bus_s;

    // Start-up phase of the mute logic
    typedef enum logic [2:0] {
        PH_STRAP = 3'b001,   // Catch pin level
        PH_WAIT  = 3'b010,   // Hold-off before mute acts
        PH_RUN   = 3'b100    // Mute follows pin
    } pcdv_phase_e;

    // Whole state of the decoder
    typedef struct packed {
        pcdv_phase_e phase;     // Start-up phase
        logic        strap;     // Pin level caught at reset
        logic        mic_gain;  // Mic gain stage enable
        logic [14:0] mute_tmr;  // Hold-off counter
        logic [11:0] smp_tmr;   // Sample period counter
        logic [2:0]  last_code; // Last sampled code
        logic [1:0]  same_cnt;  // Identical samples seen
        logic [2:0]  acc_code;  // Last accepted code
        logic        hd_en;     // Half-duplex suppression on
        logic        coef_clr;  // Coefficients held clear
        logic [5:0]  vol;       // Volume increment
        logic [11:0] err_tmr;   // Range error pulse counter
        logic        range_err; // Range error output
        logic        agc_disable_bit;      // AGC disable control
        logic        mode16;    // 16-bit mode control
        logic        mute;      // Transmit muted
        logic [15:0] tx_word;   // Outgoing sample word
        logic        hd_stat;   // Half-duplex status output
        logic        agc_act;   // AGC active
        logic [7:0]  agc_thr;   // Threshold below full scale, dB
        logic [7:0]  dac_att;   // DAC attenuation, half dB
        logic [31:0] rdata;     // Read data
    } pcdv_state_s;

endpackage : pcdv_pkg

// ===== hdl/pcdv_top.sv
/*
 * Pin control decoder with volume: debounces the three command pins,
 * drives half-duplex, coefficient clearing and volume, and handles the
 * mute and mic gain pin.
 * Assumes synchronous pins and a register port driven on sys_clk.
 */
// Operation
// R1 - Reset pin level low enables mic gain
// R2 - After 1 ms, pin change mutes
// R3 - Code acts after three stable samples
// R4 - One volume step per code entry
// R5 - Codes 011, 111 disable half-duplex
// R6 - Code 000 enables half-duplex; default on
// R7 - Code 001 holds coefficients cleared
// R8 - Code 110 decrements volume counter
// R9 - Code 101 increments volume counter
// R10 - Codes 010, 100 are ignored
// R11 - Volume counter spans 0 to 41
// R12 - AGC threshold three dB per step
// R13 - AGC limits then scales to full
// R14 - AGC inactive at increment ten
// R15 - Volume counter resets to four
// R16 - DAC attenuates 2.5 dB per increment
// R17 - AGC disable adds 10 dB attenuation
// R18 - Range error pulses 125 us, no change
// R19 - Mute sends zeros, receive full on
// R20 - Status high while half-duplex converging
// R21 - Clear code acts without debounce
// R22 - Sample once per period, single events
`timescale 1ns/10ps
`include "pcdv_defs.svh"

module pcdv_top #(
    parameter int MUTE_DLY_CYC = `PCDV_MUTE_DLY_CYC  // Mute hold-off cycles
) (
    input  wire logic              sys_clk,            // System clock
    input  wire logic              sys_rst,            // Sync reset, high
    input  wire pcdv_pkg::pcdv_bus_s bus,              // Register request
    output logic [31:0]            rdata,              // Read data
    input  wire logic              cmd_bit0,           // Command pin 0
    input  wire logic              cmd_bit1,           // Command pin 1
    input  wire logic              cmd_bit2,           // Command pin 2
    input  wire logic              mute_gain_pin,      // Mute and gain pin
    input  wire logic              ec_converged,       // Canceller trained
    input  wire logic [15:0]       mic_sample,         // Transmit sample
    input  wire logic              mic_valid,          // Sample strobe
    output logic [15:0]            serial_data_out,    // Outgoing word
    output logic                   mic_gain_en,        // Mic gain stage on
    output logic                   tx_mute,            // Transmit muted
    output logic                   rx_full_on,         // Receive full on
    output logic                   coef_clear,         // Hold coefs clear
    output logic                   hd_suppress_en,     // Half-duplex on
    output logic                   half_duplex_status, // In half-duplex
    output logic                   volume_range_error, // Range error pulse
    output logic [5:0]             vol_increment,      // Volume counter
    output logic                   agc_active,         // AGC in use
    output logic [7:0]             agc_thresh_db,      // Threshold, dB down
    output logic [7:0]             dac_atten_hdb       // Attenuation, 0.5 dB
);

    // Values after reset
    localparam pcdv_pkg::pcdv_state_s RST_STATE = '{
        phase:     pcdv_pkg::PH_STRAP,
        strap:     1'b0,
        mic_gain:  1'b1,
        mute_tmr:  15'h0000,
        smp_tmr:   12'h000,
        last_code: `PCDV_CMD_HD_EN,
        same_cnt:  2'h0,
        acc_code:  `PCDV_CMD_HD_EN,
        hd_en:     1'b1,               // see R6
        coef_clr:  1'b0,
        vol:       `PCDV_VOL_RESET,    // see R15
        err_tmr:   12'h000,
        range_err: 1'b0,
        agc_disable_bit:      1'b0,
        mode16:    1'b0,
        mute:      1'b0,
        tx_word:   16'h0000,
        hd_stat:   1'b0,
        agc_act:   1'b0,
        agc_thr:   8'h00,
        dac_att:   8'h00,
        rdata:     32'h0000_0000
    };

    pcdv_pkg::pcdv_state_s q;     // Registered state
    pcdv_pkg::pcdv_state_s d;     // Next state

    logic [2:0] cmd_code;         // Command pins as a code
    logic       tick;             // One cycle per sample period
    logic       agc_disable_bit_eff;         // AGC disable in 16-bit mode
    logic [5:0] vol_max;          // Quietest allowed increment
    logic [5:0] att_steps;        // DAC attenuation steps
    logic       go_louder;        // Accepted louder request
    logic       go_quieter;       // Accepted quieter request
    logic       range_hit;        // Request beyond the range
    logic [1:0] cnt_next;         // Next identical-sample count

    assign cmd_code = {cmd_bit2, cmd_bit1, cmd_bit0};
    assign tick     = (q.smp_tmr == 12'h000);
    assign agc_disable_bit_eff = q.agc_disable_bit & q.mode16;
    assign vol_max  = agc_disable_bit_eff ? `PCDV_VOL_MAX_AGC_DISABLE_BIT : `PCDV_VOL_MAX;

    // Steps of DAC attenuation from the volume counter
    always_comb begin
        if (agc_disable_bit_eff) begin
            att_steps = q.vol + `PCDV_AGC_DISABLE_BIT_STEPS;      // see R17
        end else if (q.vol >= `PCDV_VOL_KNEE) begin
            att_steps = q.vol - `PCDV_VOL_KNEE;        // see R16
        end else begin
            att_steps = 6'h00;                          // AGC region
        end
    end

    // Next identical-sample count, saturating at the debounce length
    always_comb begin
        if (cmd_code != q.last_code) begin
            cnt_next = 2'h1;                            // New code seen
        end else if (q.same_cnt == `PCDV_DEB_SAMPLES) begin
            cnt_next = `PCDV_DEB_SAMPLES;               // Stay stable
        end else begin
            cnt_next = q.same_cnt + 2'h1;
        end
    end

    // Volume events from a freshly accepted code
    always_comb begin
        go_louder  = 1'b0;
        go_quieter = 1'b0;
        if (tick && cnt_next == `PCDV_DEB_SAMPLES  // see R3
            && cmd_code != q.acc_code) begin       // see R4
            go_louder  = (cmd_code == `PCDV_CMD_VOL_UP);
            go_quieter = (cmd_code == `PCDV_CMD_VOL_DN);
        end
        range_hit = (go_louder && q.vol == `PCDV_VOL_MIN)    // see R18
                  || (go_quieter && q.vol >= vol_max);       // see R11
    end

    // Next state
    always_comb begin
        d       = q;
        d.rdata = 32'h0000_0000;                    // Data only after a read

        // Mute and mic gain start-up
        case (q.phase)
            pcdv_pkg::PH_STRAP: begin
                d.strap    = mute_gain_pin;
                d.mic_gain = ~mute_gain_pin;        // see R1
                d.mute_tmr = 15'(MUTE_DLY_CYC - 1);
                d.phase    = pcdv_pkg::PH_WAIT;
            end
            pcdv_pkg::PH_WAIT: begin
                if (q.mute_tmr == 15'h0000) begin
                    d.phase = pcdv_pkg::PH_RUN;     // see R2
                end else begin
                    d.mute_tmr = q.mute_tmr - 15'h0001;
                end
            end
            pcdv_pkg::PH_RUN: begin
                d.mute = (mute_gain_pin != q.strap); // see R2
            end
            default: begin
                d.phase = pcdv_pkg::PH_STRAP;       // Recover bad code
            end
        endcase

        // Sample period timer
        if (tick) begin
            d.smp_tmr = 12'(`PCDV_SAMPLE_CYC - 1);  // see R22
        end else begin
            d.smp_tmr = q.smp_tmr - 12'h001;
        end

        // Clear code follows the pins directly
        d.coef_clr = (cmd_code == `PCDV_CMD_CLR);   // see R7 see R21

        // Debounce once per sample period
        if (tick) begin
            d.last_code = cmd_code;                 // see R22
            d.same_cnt  = cnt_next;
            if (cnt_next == `PCDV_DEB_SAMPLES && cmd_code != q.acc_code) begin
                d.acc_code = cmd_code;              // see R3
                case (cmd_code)
                    `PCDV_CMD_HD_EN: begin
                        d.hd_en = 1'b1;             // see R6
                    end
                    `PCDV_CMD_HD_DIS_A, `PCDV_CMD_HD_DIS_B: begin
                        d.hd_en = 1'b0;             // see R5
                    end
                    default: begin
                        d.hd_en = q.hd_en;          // see R10
                    end
                endcase
            end
        end

        // Volume counter
        if (!range_hit && go_louder) begin
            d.vol = q.vol - 6'h01;                  // see R8
        end else if (!range_hit && go_quieter) begin
            d.vol = q.vol + 6'h01;                  // see R9
        end

        // Range error pulse
        if (range_hit) begin
            d.err_tmr   = 12'(`PCDV_ERR_CYC - 1);   // see R18
            d.range_err = 1'b1;
        end else if (q.err_tmr != 12'h000) begin
            d.err_tmr = q.err_tmr - 12'h001;
        end else begin
            d.range_err = 1'b0;
        end

        // Gain stage controls
        d.agc_act = (q.vol < `PCDV_VOL_KNEE) && !agc_disable_bit_eff;   // see R14
        if (q.vol < `PCDV_VOL_KNEE) begin
            d.agc_thr = 8'((`PCDV_VOL_KNEE - q.vol) * `PCDV_AGC_STEP_DB); // see R12 see R13
        end else begin
            d.agc_thr = 8'h00;                      // Threshold at full scale
        end
        d.dac_att = 8'(att_steps * `PCDV_DAC_STEP_HDB);      // see R16

        // Status of half-duplex during convergence
        d.hd_stat = q.hd_en && (!ec_converged || q.coef_clr); // see R20

        // Outgoing samples, zero while muted
        if (mic_valid) begin
            d.tx_word = q.mute ? 16'h0000 : mic_sample;        // see R19
        end

        // Register writes
        if (bus.wr && bus.addr == `PCDV_REG_CTRL) begin
            d.agc_disable_bit   = bus.wdata[`PCDV_CTRL_AGC_DISABLE_BIT];
            d.mode16 = bus.wdata[`PCDV_CTRL_MODE16];
        end

        // Register reads
        if (bus.rd) begin
            case (bus.addr)
                `PCDV_REG_CTRL: begin
                    d.rdata[`PCDV_CTRL_AGC_DISABLE_BIT]   = q.agc_disable_bit;
                    d.rdata[`PCDV_CTRL_MODE16] = q.mode16;
                end
                `PCDV_REG_STATUS: begin
                    d.rdata[`PCDV_ST_HD_EN]     = q.hd_en;
                    d.rdata[`PCDV_ST_CLR]       = q.coef_clr;
                    d.rdata[`PCDV_ST_MUTE]      = q.mute;
                    d.rdata[`PCDV_ST_MIC_GAIN]  = q.mic_gain;
                    d.rdata[`PCDV_ST_RANGE_ERR] = q.range_err;
                    d.rdata[`PCDV_ST_HD_STATUS] = q.hd_stat;
                    d.rdata[`PCDV_ST_AGC_ACT]   = q.agc_act;
                end
                `PCDV_REG_VOLUME: begin
                    d.rdata[5:0] = q.vol;
                end
                default: begin
                    d.rdata = 32'h0000_0000;        // Unmapped reads zero
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state
    assign rdata              = q.rdata;
    assign serial_data_out    = q.tx_word;
    assign mic_gain_en        = q.mic_gain;
    assign tx_mute            = q.mute;
    assign rx_full_on         = q.mute;        // see R19
    assign coef_clear         = q.coef_clr;
    assign hd_suppress_en     = q.hd_en;
    assign half_duplex_status = q.hd_stat;
    assign volume_range_error = q.range_err;
    assign vol_increment      = q.vol;
    assign agc_active         = q.agc_act;
    assign agc_thresh_db      = q.agc_thr;
    assign dac_atten_hdb      = q.dac_att;

endmodule : pcdv_top

// ===== sim/pcdv_top_props.sv
/* Port checker of the pin control decoder.
 * Assumes binding into pcdv_top, one clock, sync active-high reset. */
`timescale 1ns/10ps

module pcdv_top_props #(
    parameter int MUTE_DLY_CYC = 20             // Mute hold-off cycles
) (
    input wire logic        sys_clk,            // Clock
    input wire logic        sys_rst,            // Sync reset
    input wire logic        cmd_bit0,           // Command pin 0
    input wire logic        cmd_bit1,           // Command pin 1
    input wire logic        cmd_bit2,           // Command pin 2
    input wire logic        mute_gain_pin,      // Mute pin
    input wire logic        ec_converged,       // Canceller trained
    input wire logic        mic_valid,          // Sample strobe
    input wire logic [15:0] serial_data_out,    // Outgoing word
    input wire logic        mic_gain_en,        // Gain stage on
    input wire logic        tx_mute,            // Muted
    input wire logic        rx_full_on,         // Receive full on
    input wire logic        coef_clear,         // Coefs held clear
    input wire logic        hd_suppress_en,     // Half-duplex on
    input wire logic        half_duplex_status, // In half-duplex
    input wire logic        volume_range_error, // Error pulse
    input wire logic [5:0]  vol_increment,      // Volume counter
    input wire logic [7:0]  agc_thresh_db       // Threshold, dB down
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [2:0]  cmd;   // Command code
    logic [11:0] err_q; // Error pulse run length
    logic [15:0] rel_q; // Cycles since release

    assign cmd = {cmd_bit2, cmd_bit1, cmd_bit0};

    // Length of the error pulse and time since reset, saturating
    always_ff @(posedge sys_clk) begin
        err_q <= (volume_range_error && !sys_rst) ? err_q + 12'h001 : 12'h000;
        rel_q <= sys_rst ? 16'h0000 : ((rel_q == 16'hFFFF) ? rel_q : rel_q + 16'h0001);
    end

    property p_clr_on; cmd == 3'h1 |=> coef_clear; endproperty
    a_clr_on: assert property (p_clr_on) else $error("clear late");
    property p_clr_off; cmd != 3'h1 |=> !coef_clear; endproperty
    a_clr_off: assert property (p_clr_off) else $error("clear held");
    property p_vol_max; vol_increment <= 6'h29; endproperty
    a_vol_max: assert property (p_vol_max) else $error("volume out of span");
    property p_vol_step; !$past(sys_rst) && vol_increment != $past(vol_increment) |->
        vol_increment == $past(vol_increment) + 6'h01 || vol_increment == $past(vol_increment) - 6'h01;
    endproperty
    a_vol_step: assert property (p_vol_step) else $error("volume jumped");
    property p_err_len; $fell(volume_range_error) && !$past(sys_rst) |-> err_q == 12'hC35;
    endproperty
    a_err_len: assert property (p_err_len) else $error("error pulse length");
    property p_err_hold; $rose(volume_range_error) |->
        $stable(vol_increment) && (vol_increment == 6'h00 || vol_increment >= 6'h1F);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error off the ends");
    property p_thr; !$past(sys_rst) |-> agc_thresh_db == (($past(vol_increment) < 6'h0A) ?
        (8'h0A - {2'h0, $past(vol_increment)}) * 8'h03 : 8'h00);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold wrong");
    property p_mute_hold; rel_q < MUTE_DLY_CYC |-> !tx_mute; endproperty
    a_mute_hold: assert property (p_mute_hold) else $error("early mute");
    property p_mute_follow; rel_q > MUTE_DLY_CYC + 4 && $stable(mute_gain_pin) |=>
        tx_mute == $past(mute_gain_pin == mic_gain_en) && rx_full_on == tx_mute;
    endproperty
    a_mute_follow: assert property (p_mute_follow) else $error("mute wrong");
    property p_mute_data; mic_valid && tx_mute |=> serial_data_out == 16'h0000; endproperty
    a_mute_data: assert property (p_mute_data) else $error("muted data sent");
    property p_hd_stat; !$past(sys_rst) |->
        half_duplex_status == $past(hd_suppress_en && (!ec_converged || coef_clear));
    endproperty
    a_hd_stat: assert property (p_hd_stat) else $error("status wrong");
    property p_gain; !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(mic_gain_en); endproperty
    a_gain: assert property (p_gain) else $error("gain moved");
endmodule : pcdv_top_props

bind pcdv_top pcdv_top_props #(.MUTE_DLY_CYC(MUTE_DLY_CYC)) u_props (.sys_clk, .sys_rst,
    .cmd_bit0, .cmd_bit1, .cmd_bit2, .mute_gain_pin, .ec_converged, .mic_valid,
    .serial_data_out, .mic_gain_en, .tx_mute, .rx_full_on, .coef_clear, .hd_suppress_en,
    .half_duplex_status, .volume_range_error, .vol_increment, .agc_thresh_db);

// ===== sim/pcdv_ctrl_model.sv
/* Controller model driving the three command pins.
 * Assumes the decoder samples the pins once per sample period. */
`timescale 1ns/10ps
`include "pcdv_defs.svh"

module pcdv_ctrl_model (
    input  wire logic sys_clk,  // System clock
    output logic      cmd_bit0, // Command pin 0
    output logic      cmd_bit1, // Command pin 1
    output logic      cmd_bit2  // Command pin 2
);
    logic [2:0] cur_q = 3'h0; // Code on the pins

    assign {cmd_bit2, cmd_bit1, cmd_bit0} = cur_q;

    // Put a code on the pins just after an edge
    task automatic set(input logic [2:0] code);
        @(posedge sys_clk);
        cur_q <= code;
    endtask : set

    // Hold a code three sample periods, plus slack for a slow controller
    task automatic send(input logic [2:0] code, input int slack);
        set(code);
        repeat (3 * `PCDV_SAMPLE_CYC + slack) @(posedge sys_clk);
    endtask : send
endmodule : pcdv_ctrl_model

// ===== sim/tb_pin_control_decoder_volume.sv
/* Testbench of the pin control decoder: codes, volume, mute, clearing, registers.
 * Assumes pcdv_top, the controller model and the bound checker. */
`timescale 1ns/10ps

module tb_pin_control_decoder_volume;
    logic                sys_clk, sys_rst, mute_gain_pin, ec_converged;  // Inputs
    logic                mic_valid, cmd_bit0, cmd_bit1, cmd_bit2;        // Pins
    logic [15:0]         mic_sample, serial_data_out;                     // Sample words
    pcdv_pkg::pcdv_bus_s bus;                                             // Register request
    logic [31:0]         rdata;                                           // Read data
    logic                mic_gain_en, tx_mute, rx_full_on, coef_clear;    // Flags
    logic                hd_suppress_en, half_duplex_status, volume_range_error, agc_active;
    logic [5:0]          vol_increment, vol;                              // Counter, expected
    logic [7:0]          agc_thresh_db, dac_atten_hdb;                    // Levels
    logic                strap, hd, err;                                  // Expectations
    int                  errors, num_checks;                              // Tallies
    logic                err_prev;                                        // Error pin, last cycle
    int                  err_rises = 0, rises;                            // Error pulses seen
    // Volume steps separated by codes 011, 000, 111 and 010
    logic [2:0]          codes [10] = '{3'h6, 3'h3, 3'h6, 3'h0, 3'h6, 3'h7, 3'h6, 3'h2, 3'h6, 3'h5};

    pcdv_top #(.MUTE_DLY_CYC(20)) uut (.sys_clk, .sys_rst, .bus, .rdata, .cmd_bit0, .cmd_bit1,
        .cmd_bit2, .mute_gain_pin, .ec_converged, .mic_sample, .mic_valid, .serial_data_out,
        .mic_gain_en, .tx_mute, .rx_full_on, .coef_clear, .hd_suppress_en, .half_duplex_status,
        .volume_range_error, .vol_increment, .agc_active, .agc_thresh_db, .dac_atten_hdb);
    pcdv_ctrl_model cm (.sys_clk, .cmd_bit0, .cmd_bit1, .cmd_bit2);

    // Expected threshold, dB below full scale
    function automatic logic [7:0] thr_of(logic [5:0] v);
        return (v < 6'h0A) ? (8'h0A - {2'h0, v}) * 8'h03 : 8'h00;
    endfunction : thr_of

    // Expected attenuation in half dB
    function automatic logic [7:0] att_of(logic [5:0] v, logic ad);
        if (ad) return ({2'h0, v} + 8'h04) * 8'h05;
        return (v >= 6'h0A) ? ({2'h0, v} - 8'h0A) * 8'h05 : 8'h00;
    endfunction : att_of

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rd

    // One transmit word, zero expected while muted
    task automatic mic(logic muted);
        logic [15:0] s;
        s = 16'($urandom);
        @(posedge sys_clk);
        mic_sample <= s;
        mic_valid <= 1'b1;
        @(posedge sys_clk);
        mic_valid <= 1'b0;
        #1 check("sdo", serial_data_out, muted ? 16'h0000 : s);
    endtask : mic

    task automatic flip(logic v);
        @(posedge sys_clk);
        mute_gain_pin <= v;
        step(3);
    endtask : flip

    task automatic canc(logic v);
        @(posedge sys_clk);
        ec_converged <= v;
        step(2);
    endtask : canc

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Count error pulses, which may end before the controller lets go
    always @(posedge sys_clk) begin
        err_prev <= volume_range_error;
        if (volume_range_error && !err_prev) err_rises <= err_rises + 1;
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        $display("[FAIL] run expected done seen hang");
        summarize();
    end

    initial begin
        strap = 1'($urandom(32'h0A70));
        sys_rst = 1'b1;
        mute_gain_pin = strap;
        ec_converged = 1'b1;
        mic_valid = 1'b0;
        mic_sample = 16'h0000;
        bus = '0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        step(1);
        check("gain", mic_gain_en, !strap);
        check("vol", vol_increment, 6'h04);
        check("hd", hd_suppress_en, 1'b1);
        $display("test reset done");
        vol = 6'h04;
        hd = 1'b1;
        foreach (codes[i]) begin
            rises = err_rises;
            cm.send(codes[i], $urandom_range(40, 0));
            step(2); // Gain outputs lag the counter by one cycle
            err = (codes[i] == 3'h6) && (vol == 6'h00);
            case (codes[i])
                3'h6: vol = err ? vol : vol - 6'h01;
                3'h5: vol = vol + 6'h01;
                3'h3, 3'h7: hd = 1'b0;
                3'h0: hd = 1'b1;
                default: ; // Idle codes change nothing
            endcase
            check("vol", vol_increment, vol);
            check("hd", hd_suppress_en, hd);
            check("err", err_rises != rises, err);
            check("thr", agc_thresh_db, thr_of(vol));
            check("att", dac_atten_hdb, att_of(vol, 1'b0));
            check("agc", agc_active, vol < 6'h0A);
            if (i == 0) begin
                flip(~strap);
                check("mute", tx_mute, 1'b1);
                check("rxon", rx_full_on, 1'b1);
                mic(1'b1);
                flip(strap);
                check("mute", tx_mute, 1'b0);
                mic(1'b0);
                cm.set(3'h1);
                step(2);
                check("clr", coef_clear, 1'b1);
                check("hds", half_duplex_status, 1'b1);
                cm.set(3'h6);
                step(2);
                check("clr", coef_clear, 1'b0);
                canc(1'b0);
                check("hds", half_duplex_status, 1'b1);
                canc(1'b1);
                check("hds", half_duplex_status, 1'b0);
            end
        end
        $display("test codes done");
        wr(8'h00, 32'h3);
        wr(8'h04, 32'hFF);
        rd(8'h00, 32'h3);
        rd(8'h08, {26'h0, vol});
        rd(8'h0C, 32'h0);
        rd(8'h04, {28'h0, ~strap, 2'h0, hd});
        check("att", dac_atten_hdb, att_of(vol, 1'b1));
        check("agc", agc_active, 1'b0);
        wr(8'h00, 32'h0);
        step(2);
        check("att", dac_atten_hdb, att_of(vol, 1'b0));
        $display("test regs done");
        summarize();
    end
endmodule : tb_pin_control_decoder_volume
